// >>> inc/setpoint_pkg.sv
// constants for the converter setpoint register bank
package setpoint_pkg;

  // register addresses and reset values
  localparam logic [7:0] ADDR_OUTPUT_LEVEL = 8'h03;
  localparam logic [7:0] ADDR_TUNING       = 8'h05;
  localparam logic [7:0] RST_OUTPUT_LEVEL  = 8'h5c;
  localparam logic [7:0] RST_TUNING        = 8'h45;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // tuning register field positions
  localparam int FIXED_FREQ_BIT = 7;
  localparam int FAST_START_BIT = 6;
  localparam int DISCH_MSB      = 5;
  localparam int DISCH_LSB      = 4;
  localparam int FLOOR_BIT      = 3;
  localparam int RAMP_MSB       = 2;
  localparam int RAMP_LSB       = 0;

  // output level scale, millivolts
  localparam logic [7:0]  LEVEL_LINEAR_MAX = 8'hb4;
  localparam logic [12:0] LEVEL_BASE_MV    = 13'h03e8;
  localparam logic [12:0] LEVEL_STEP_MV    = 13'h0019;
  localparam logic [12:0] LEVEL_CLAMP_MV   = 13'h157c;

  // soft-start current floor, milliamps; high level is twice this
  localparam logic [10:0] FLOOR_LOW_MA = 11'h1f4;

  // discharge strength, milliamps, per code 00..11
  localparam logic [6:0] DISCH_MA [4] = '{7'h00, 7'h22, 7'h43, 7'h64};

  // soft-start duration, microseconds, per code 000..111
  localparam logic [14:0] RAMP_US [8] = '{
    15'h0100, 15'h0200, 15'h0400, 15'h0780,
    15'h0e00, 15'h1d80, 15'h2580, 15'h5f00
  };

endpackage

// >>> hw/converter_setpoint_regs.sv
// setpoint and tuning register bank behind the serial target engine
`timescale 1ns/1ps

module converter_setpoint_regs (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        WR_STROBE,
  input  wire logic        RD_REQ,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  WR_DATA,
  output logic      [7:0]  RD_DATA,
  output logic             RD_VALID,
  output logic      [7:0]  OUTPUT_LEVEL,
  output logic      [12:0] TARGET_MV,
  output logic             FORCED_FIXED_FREQUENCY,
  output logic             FAST_STARTUP_EN,
  output logic      [1:0]  DISCHARGE_STRENGTH_SEL,
  output logic      [6:0]  DISCHARGE_MA,
  output logic             STARTUP_CURRENT_FLOOR,
  output logic      [10:0] CURRENT_FLOOR_MA,
  output logic      [2:0]  SOFTSTART_DURATION_SEL,
  output logic      [14:0] SOFTSTART_US
);

  logic [7:0]  level_ff;
  logic [7:0]  nxt_level;
  logic [7:0]  tuning_ff;
  logic [7:0]  nxt_tuning;
  logic [12:0] target_ff;
  logic [12:0] nxt_target;
  logic [6:0]  disch_ma_ff;
  logic [6:0]  nxt_disch_ma;
  logic [10:0] floor_ma_ff;
  logic [10:0] nxt_floor_ma;
  logic [14:0] ramp_us_ff;
  logic [14:0] nxt_ramp_us;
  logic [7:0]  rd_data_ff;
  logic [7:0]  nxt_rd_data;
  logic        rd_valid_ff;
  logic        nxt_rd_valid;
  logic        wr_level;
  logic        wr_tuning;

  // the engine pulses WR_STROBE at the final ack's falling edge
  assign wr_level  = CE && WR_STROBE
                     && (REG_ADDR == setpoint_pkg::ADDR_OUTPUT_LEVEL);
  assign wr_tuning = CE && WR_STROBE
                     && (REG_ADDR == setpoint_pkg::ADDR_TUNING);

  // register contents and their decoded values
  always_comb begin
    nxt_level  = wr_level  ? WR_DATA : level_ff;
    nxt_tuning = wr_tuning ? WR_DATA : tuning_ff;
    // decodes follow the next value so they never lag the field
    if (nxt_level <= setpoint_pkg::LEVEL_LINEAR_MAX) begin
      nxt_target = 13'(setpoint_pkg::LEVEL_BASE_MV
                   + 13'(nxt_level) * setpoint_pkg::LEVEL_STEP_MV);
    end else begin
      nxt_target = setpoint_pkg::LEVEL_CLAMP_MV;
    end
    nxt_disch_ma = setpoint_pkg::DISCH_MA[
      nxt_tuning[setpoint_pkg::DISCH_MSB:setpoint_pkg::DISCH_LSB]];
    if (nxt_tuning[setpoint_pkg::FLOOR_BIT]) begin
      nxt_floor_ma = 11'(setpoint_pkg::FLOOR_LOW_MA << 1);
    end else begin
      nxt_floor_ma = setpoint_pkg::FLOOR_LOW_MA;
    end
    nxt_ramp_us = setpoint_pkg::RAMP_US[
      nxt_tuning[setpoint_pkg::RAMP_MSB:setpoint_pkg::RAMP_LSB]];
  end

  // read port: one cycle from request to data
  always_comb begin
    nxt_rd_data  = rd_data_ff;
    nxt_rd_valid = rd_valid_ff;
    if (CE) begin
      nxt_rd_valid = RD_REQ;
      if (RD_REQ) begin
        case (REG_ADDR)
          setpoint_pkg::ADDR_OUTPUT_LEVEL: nxt_rd_data = level_ff;
          setpoint_pkg::ADDR_TUNING:       nxt_rd_data = tuning_ff;
          default: nxt_rd_data = setpoint_pkg::READ_UNMAPPED;
        endcase
      end
    end
  end

  // reset is honoured even while CE is low so a frozen bank can be cleared
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      level_ff    <= setpoint_pkg::RST_OUTPUT_LEVEL;
      tuning_ff   <= setpoint_pkg::RST_TUNING;
      // decoded resets except the current floor follow the reset codes so the two cannot drift
      target_ff   <= 13'(setpoint_pkg::LEVEL_BASE_MV
                     + 13'(setpoint_pkg::RST_OUTPUT_LEVEL)
                     * setpoint_pkg::LEVEL_STEP_MV);
      disch_ma_ff <= setpoint_pkg::DISCH_MA[setpoint_pkg::RST_TUNING[
                       setpoint_pkg::DISCH_MSB:setpoint_pkg::DISCH_LSB]];
      floor_ma_ff <= setpoint_pkg::FLOOR_LOW_MA;
      ramp_us_ff  <= setpoint_pkg::RAMP_US[setpoint_pkg::RST_TUNING[
                       setpoint_pkg::RAMP_MSB:setpoint_pkg::RAMP_LSB]];
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      level_ff    <= nxt_level;
      tuning_ff   <= nxt_tuning;
      target_ff   <= nxt_target;
      disch_ma_ff <= nxt_disch_ma;
      floor_ma_ff <= nxt_floor_ma;
      ramp_us_ff  <= nxt_ramp_us;
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign RD_DATA                = rd_data_ff;
  assign RD_VALID               = rd_valid_ff;
  assign OUTPUT_LEVEL           = level_ff;
  assign TARGET_MV              = target_ff;
  assign FORCED_FIXED_FREQUENCY =
    tuning_ff[setpoint_pkg::FIXED_FREQ_BIT];
  assign FAST_STARTUP_EN        =
    tuning_ff[setpoint_pkg::FAST_START_BIT];
  assign DISCHARGE_STRENGTH_SEL =
    tuning_ff[setpoint_pkg::DISCH_MSB:setpoint_pkg::DISCH_LSB];
  assign DISCHARGE_MA           = disch_ma_ff;
  assign STARTUP_CURRENT_FLOOR  = tuning_ff[setpoint_pkg::FLOOR_BIT];
  assign CURRENT_FLOOR_MA       = floor_ma_ff;
  assign SOFTSTART_DURATION_SEL =
    tuning_ff[setpoint_pkg::RAMP_MSB:setpoint_pkg::RAMP_LSB];
  assign SOFTSTART_US           = ramp_us_ff;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_reset_tuning: assert property (
    $past(RESET) |-> (tuning_ff == 8'h45 && DISCHARGE_MA == 7'h00
                      && CURRENT_FLOOR_MA == 11'h1f4
                      && SOFTSTART_US == 15'h1d80))
    else $error("tuning register not at reset value after reset");

  a_tuning_write: assert property (
    (CE && WR_STROBE && REG_ADDR == setpoint_pkg::ADDR_TUNING)
      |=> (tuning_ff == $past(WR_DATA)))
    else $error("tuning write not applied next cycle");

  a_level_hold: assert property (
    !(CE && WR_STROBE && REG_ADDR == setpoint_pkg::ADDR_OUTPUT_LEVEL)
      |=> $stable(level_ff))
    else $error("output level changed without a write");

  a_target_linear: assert property (
    (level_ff <= 8'hb4)
      |-> (TARGET_MV == 13'(13'h03e8 + 13'(level_ff) * 13'h0019)))
    else $error("target off the linear scale");

  a_target_clamp: assert property (
    (level_ff > 8'hb4) |-> (TARGET_MV == 13'h157c))
    else $error("target not clamped at top");

  a_unmapped_read: assert property (
    (CE && RD_REQ && REG_ADDR != setpoint_pkg::ADDR_OUTPUT_LEVEL
     && REG_ADDR != setpoint_pkg::ADDR_TUNING)
      |=> (RD_VALID && RD_DATA == 8'h00))
    else $error("unmapped read not zero");

  a_tuning_readback: assert property (
    (CE && RD_REQ && REG_ADDR == setpoint_pkg::ADDR_TUNING)
      |=> (RD_VALID && RD_DATA == $past(tuning_ff)))
    else $error("tuning readback mismatch");

  a_floor_double: assert property (
    STARTUP_CURRENT_FLOOR |-> (CURRENT_FLOOR_MA == 11'h3e8))
    else $error("current floor not doubled");

  a_discharge_fast: assert property (
    (DISCHARGE_STRENGTH_SEL == 2'h3) |-> (DISCHARGE_MA == 7'h64))
    else $error("fast discharge strength wrong");

  a_ramp_longest: assert property (
    (SOFTSTART_DURATION_SEL == 3'h7) |-> (SOFTSTART_US == 15'h5f00))
    else $error("longest soft-start duration wrong");

  a_fast_start_bit: assert property (
    (CE && WR_STROBE && REG_ADDR == setpoint_pkg::ADDR_TUNING)
      |=> (FAST_STARTUP_EN == $past(WR_DATA[6])
           && FORCED_FIXED_FREQUENCY == $past(WR_DATA[7])))
    else $error("feature bits do not follow write");

  a_reset_level: assert property (
    $past(RESET) |-> (OUTPUT_LEVEL == 8'h5c && TARGET_MV == 13'h0ce4
                      && !RD_VALID))
    else $error("output level not at reset value after reset");

  a_tuning_hold: assert property (
    !(CE && WR_STROBE && REG_ADDR == setpoint_pkg::ADDR_TUNING)
      |=> $stable(tuning_ff))
    else $error("tuning register changed without a write");

  a_read_pulse: assert property (
    (CE && !RD_REQ) |=> !RD_VALID)
    else $error("read valid stood longer than one cycle");

  // a low enable must swallow every request, reads included
  a_ce_freeze: assert property (
    !CE |=> ($stable(level_ff) && $stable(tuning_ff)
             && $stable(RD_DATA) && $stable(RD_VALID)))
    else $error("state moved while clock enable low");

  a_floor_low: assert property (
    !STARTUP_CURRENT_FLOOR |-> (CURRENT_FLOOR_MA == 11'h1f4))
    else $error("current floor not at low level");

  a_discharge_off: assert property (
    (DISCHARGE_STRENGTH_SEL == 2'h0) |-> (DISCHARGE_MA == 7'h00))
    else $error("discharge not off");

  a_ramp_shortest: assert property (
    (SOFTSTART_DURATION_SEL == 3'h0) |-> (SOFTSTART_US == 15'h0100))
    else $error("shortest soft-start duration wrong");

endmodule // converter_setpoint_regs

// >>> tb/host_model.sv
// byte-level request driver standing in for the serial target engine
`timescale 1ns/1ps

module host_model (
  input  wire logic       clock,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            wr_strobe,
  output logic            rd_req,
  output logic      [7:0] reg_addr,
  output logic      [7:0] wr_data
);
  initial begin
    wr_strobe = 1'b0;
    rd_req    = 1'b0;
    reg_addr  = 8'h00;
    wr_data   = 8'h00;
  end

  // released lines show the inverse, so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_strobe = 1'b1;
    reg_addr  = a;
    wr_data   = d;
    @(negedge clock);
    wr_strobe = 1'b0;
    reg_addr  = ~a;
    wr_data   = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge clock);
    rd_req   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    rd_req   = 1'b0;
    reg_addr = ~a;
    d        = rd_data;
    v        = rd_valid;
  endtask
endmodule // host_model

// >>> tb/converter_setpoint_regs_tb.sv
// self-checking bench for the converter setpoint register bank
`timescale 1ns/1ps

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module converter_setpoint_regs_tb;
  logic clock, reset, ce, wrs, rdq, rv;
  logic [7:0] addr, wd, rdat, d, t, c;
  logic       v;
  logic [7:0] lvl;
  logic [12:0] mv;
  logic ff, fs, fl;
  logic [1:0] ds;
  logic [6:0] dma;
  logic [10:0] fma;
  logic [2:0] rs;
  logic [14:0] rus;
  int fail_count = 0;
  int comparisons = 0;
  int us [8] = '{256, 512, 1024, 1920, 3584, 7552, 9600, 24320};
  int ma [4] = '{0, 34, 67, 100};

  converter_setpoint_regs u_dut (.CLOCK(clock), .RESET(reset), .CE(ce),
    .WR_STROBE(wrs), .RD_REQ(rdq), .REG_ADDR(addr), .WR_DATA(wd),
    .RD_DATA(rdat), .RD_VALID(rv), .OUTPUT_LEVEL(lvl), .TARGET_MV(mv),
    .FORCED_FIXED_FREQUENCY(ff), .FAST_STARTUP_EN(fs),
    .DISCHARGE_STRENGTH_SEL(ds), .DISCHARGE_MA(dma),
    .STARTUP_CURRENT_FLOOR(fl), .CURRENT_FLOOR_MA(fma),
    .SOFTSTART_DURATION_SEL(rs), .SOFTSTART_US(rus));

  host_model u_host (.clock(clock), .rd_valid(rv), .rd_data(rdat),
    .wr_strobe(wrs), .rd_req(rdq), .reg_addr(addr), .wr_data(wd));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic complete_run;
    $display("mismatches %0d of %0d checks", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    reset = 1'b1;
    repeat (6) @(negedge clock);
    reset = 1'b0;
  endtask

  // tuning fields and their decoded values against the written byte
  task automatic chk_tuning(input logic [7:0] x);
    `CHK(ff, x[7])
    `CHK(fs, x[6])
    `CHK(ds, x[5:4])
    `CHK(dma, 7'(ma[x[5:4]]))
    `CHK(fl, x[3])
    `CHK(fma, (x[3] ? 11'd1000 : 11'd500))
    `CHK(rs, x[2:0])
    `CHK(rus, 15'(us[x[2:0]]))
    u_host.rd(8'h05, d, v);
    `CHK({v, d}, {1'b1, x})
  endtask

  initial begin
    ce    = 1'b1;
    do_reset();
    chk_tuning(8'h45);
    u_host.rd(8'h03, d, v);
    `CHK(d, 8'h5c)
    for (int i = 0; i < 8; i++) begin
      t = {i[0], ~i[0], i[1:0], i[2], i[2:0]};
      u_host.wr(8'h05, t);
      chk_tuning(t);
    end
    // odd passes walk the linear end 0xb5, 0xb4, 0xb3
    for (int i = 0; i < 6; i++) begin
      c = i[0] ? 8'hb5 - 8'(i >> 1) : 8'(i * 60);
      u_host.wr(8'h03, c);
      `CHK(mv, (c <= 8'hb4 ? 13'(1000 + 25 * c) : 13'd5500))
      `CHK(lvl, c)
    end
    u_host.wr(8'hff, 8'hff);
    `CHK(lvl, c)
    `CHK(mv, 13'(1000 + 25 * c))
    // clock enable low must swallow the request
    ce = 1'b0;
    u_host.wr(8'h05, 8'h00);
    ce = 1'b1;
    chk_tuning(t);
    u_host.wr(8'h02, 8'hff);
    u_host.rd(8'h02, d, v);
    `CHK({v, d}, 9'h100)
    u_host.rd(8'h07, d, v);
    `CHK({v, d}, 9'h100)
    // reset must still act while the clock enable is low
    ce = 1'b0;
    do_reset();
    ce = 1'b1;
    chk_tuning(8'h45);
    `CHK(mv, 13'd3300)
    `CHK(lvl, 8'h5c)
    complete_run();
  end

  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
endmodule // converter_setpoint_regs_tb
